// ---- rwi_pkg.sv ----
// constants, types and functions for the reset and wake-up register bank
// Functional notes
// - non power-on resets set every implemented interrupt priority bit to one
// - wake-up from sleep sets the flag bits that record its cause
// - interrupt wake-up with a global enable loads the matching vector
// - that wake-up copies the program counter into top of stack
// - that wake-up advances the return stack pointer by one
// - port A bits 6 and 7 exist only when the oscillator frees them
// - analog config field resets to 000 if default bit set, else 111
// - program and data memory have separate buses usable in one cycle
// - every reset clears the return stack pointer to zero
package rwi_pkg;

  // =====================================================================
  // widths
  localparam int PC_W  = 21;
  localparam int SP_W  = 5;

  // =====================================================================
  // data bus register indexes
  localparam logic [3:0] ADDR_IRQ_PRIORITY_REGS    = 4'h0;
  localparam logic [3:0] ADDR_IPR2    = 4'h1;
  localparam logic [3:0] ADDR_PIR1    = 4'h2;
  localparam logic [3:0] ADDR_PIR2    = 4'h3;
  localparam logic [3:0] ADDR_PIE1    = 4'h4;
  localparam logic [3:0] ADDR_PIE2    = 4'h5;
  localparam logic [3:0] ADDR_OSCTUNE = 4'h6;
  localparam logic [3:0] ADDR_PORT_A_DIRECTION   = 4'h7;
  localparam logic [3:0] ADDR_PORT_A_LATCH    = 4'h8;
  localparam logic [3:0] ADDR_PORT_A_PINS   = 4'h9;
  localparam logic [3:0] ADDR_INTCON  = 4'hA;
  localparam logic [3:0] ADDR_ANCFG   = 4'hB;
  localparam logic [3:0] ADDR_RETURN_STACK_POINTER  = 4'hC;

  // =====================================================================
  // implemented bit masks and reset values
  localparam logic [7:0] IRQ_PRIORITY_REGS_MASK    = 8'hFF;
  localparam logic [7:0] IPR2_MASK    = 8'hDF;
  localparam logic [7:0] OSCTUNE_MASK = 8'hDF;
  localparam logic [7:0] PORT_A_PINS_HI     = 8'hC0;
  localparam logic [7:0] ZERO8        = 8'h00;
  localparam logic [7:0] TRIS_RST     = 8'hFF;
  localparam logic [2:0] ANCFG_ANALOG = 3'h0;
  localparam logic [2:0] ANCFG_DIGITAL = 3'h7;
  localparam int         HIGH_GLOBAL_IRQ_ENABLE_BIT     = 7;
  localparam int         LOW_GLOBAL_IRQ_ENABLE_BIT     = 6;

  // =====================================================================
  // vectors and stack
  localparam logic [PC_W-1:0] PC_RESET   = 21'h000000;
  localparam logic [PC_W-1:0] VEC_HIGH   = 21'h000008;
  localparam logic [PC_W-1:0] VEC_LOW    = 21'h000018;
  localparam logic [SP_W-1:0] SP_RESET   = 5'h00;
  localparam logic [SP_W-1:0] SP_ONE     = 5'h01;
  localparam logic [PC_W-1:0] PC_STEP    = 21'h000002;

  // =====================================================================
  // carriers
  typedef struct packed {
    logic por;
    logic bor;
    logic wdt;
    logic instr;
    logic stack;
  } rwi_reset_evt_t;

  typedef struct packed {
    logic       valid;
    logic       is_irq;
    logic       high_prio;
    logic [7:0] intcon_set;
    logic [7:0] pir1_set;
    logic [7:0] pir2_set;
  } rwi_wake_t;

  function automatic logic [7:0] rwi_pa_mask(input logic freed);
    rwi_pa_mask = freed ? 8'hFF : ~PORT_A_PINS_HI;
  endfunction

endpackage

// ---- rwi_reg_bank.sv ----
// reset and wake-up initialisation of interrupt, oscillator and port A registers
`timescale 1ns/1ps
module rwi_reg_bank
  import rwi_pkg::*;
(
  // clock and power-on reset
  input  wire logic           mclk,
  input  wire logic           reset,
  // reset and wake events
  input  wire logic           external_reset_pin_n,
  input  wire rwi_reset_evt_t rst_evt,
  input  wire rwi_wake_t      wake,
  input  wire logic           analog_default_cfg_bit,
  input  wire logic           osc_frees_ra67,
  // port A pins
  input  wire logic [7:0]     port_a_pins_in,
  // data memory bus
  input  wire logic           data_wr,
  input  wire logic [3:0]     data_addr,
  input  wire logic [7:0]     data_wdata,
  output logic      [7:0]     data_rdata,
  // program memory bus, port A drive and stack outputs
  output logic [PC_W-1:0]     prog_addr,
  output logic [7:0]          port_a_latch_out,
  output logic [7:0]          port_a_direction_out,
  output logic [PC_W-1:0]     top_of_stack,
  output logic [SP_W-1:0]     return_stack_pointer
);

  // =====================================================================
  // synchronisers for pins
  logic       external_reset_pin_s1_reg, external_reset_pin_s2_reg;
  logic [7:0] pa_s1_reg, pa_s2_reg;

  always_ff @(posedge mclk) begin
    external_reset_pin_s1_reg <= ~external_reset_pin_n;
    external_reset_pin_s2_reg <= external_reset_pin_s1_reg;
    pa_s1_reg   <= port_a_pins_in;
    pa_s2_reg   <= pa_s1_reg;
  end

  // =====================================================================
  // reset classes
  logic por_cls;
  logic warm_cls;
  logic wake_vec;
  logic [7:0] pa_mask;

  assign por_cls  = reset | rst_evt.por | rst_evt.bor;
  assign warm_cls = external_reset_pin_s2_reg | rst_evt.wdt | rst_evt.instr | rst_evt.stack;
  assign pa_mask  = rwi_pa_mask(osc_frees_ra67);

  // =====================================================================
  // register state
  logic [7:0]      irq_priority_regs_reg, ipr2_reg, pir1_reg, pir2_reg, pie1_reg, pie2_reg;
  logic [7:0]      osctune_reg, port_a_direction_reg, port_a_latch_reg, intcon_reg;
  logic [2:0]      ancfg_reg;
  logic [PC_W-1:0] pc_reg, tos_reg;
  logic [SP_W-1:0] sp_reg;
  logic [7:0]      rdata_reg;

  logic [7:0]      irq_priority_regs_next, ipr2_next, pir1_next, pir2_next, pie1_next, pie2_next;
  logic [7:0]      osctune_next, port_a_direction_next, port_a_latch_next, intcon_next;
  logic [2:0]      ancfg_next;
  logic [PC_W-1:0] pc_next, tos_next;
  logic [SP_W-1:0] sp_next;
  logic [7:0]      rdata_next;

  assign wake_vec = wake.valid & wake.is_irq &
                    (intcon_reg[HIGH_GLOBAL_IRQ_ENABLE_BIT] | intcon_reg[LOW_GLOBAL_IRQ_ENABLE_BIT]);

  always_comb begin
    irq_priority_regs_next    = irq_priority_regs_reg;
    ipr2_next    = ipr2_reg;
    pir1_next    = pir1_reg;
    pir2_next    = pir2_reg;
    pie1_next    = pie1_reg;
    pie2_next    = pie2_reg;
    osctune_next = osctune_reg;
    port_a_direction_next   = port_a_direction_reg;
    port_a_latch_next    = port_a_latch_reg;
    intcon_next  = intcon_reg;
    ancfg_next   = ancfg_reg;
    pc_next      = pc_reg + PC_STEP;
    tos_next     = tos_reg;
    sp_next      = sp_reg;
    // software writes first, so a wake flag in the same cycle still lands
    if (data_wr) begin
      if (data_addr == ADDR_IRQ_PRIORITY_REGS) begin
        irq_priority_regs_next = data_wdata & IRQ_PRIORITY_REGS_MASK;
      end else if (data_addr == ADDR_IPR2) begin
        ipr2_next = data_wdata & IPR2_MASK;
      end else if (data_addr == ADDR_PIR1) begin
        pir1_next = data_wdata;
      end else if (data_addr == ADDR_PIR2) begin
        pir2_next = data_wdata & IPR2_MASK;
      end else if (data_addr == ADDR_PIE1) begin
        pie1_next = data_wdata;
      end else if (data_addr == ADDR_PIE2) begin
        pie2_next = data_wdata & IPR2_MASK;
      end else if (data_addr == ADDR_OSCTUNE) begin
        osctune_next = data_wdata & OSCTUNE_MASK;
      end else if (data_addr == ADDR_PORT_A_DIRECTION) begin
        port_a_direction_next = data_wdata;
      end else if (data_addr == ADDR_PORT_A_LATCH) begin
        port_a_latch_next = data_wdata;
      end else if (data_addr == ADDR_INTCON) begin
        intcon_next = data_wdata;
      end else if (data_addr == ADDR_ANCFG) begin
        ancfg_next = data_wdata[2:0];
      end else if (data_addr == ADDR_RETURN_STACK_POINTER) begin
        sp_next = data_wdata[SP_W-1:0];
      end
    end
    // wake keeps every register but intcon, pir1 and pir2, which take its flags, and pc, top of stack and stack pointer, which an interrupt wake loads
    if (wake.valid) begin
      intcon_next = intcon_next | wake.intcon_set;
      pir1_next   = pir1_next | wake.pir1_set;
      pir2_next   = pir2_next | (wake.pir2_set & IPR2_MASK);
    end
    if (wake_vec) begin
      pc_next  = wake.high_prio ? VEC_HIGH : VEC_LOW;
      tos_next = pc_reg;
      sp_next  = sp_reg + SP_ONE;
    end
    if (por_cls | warm_cls) begin
      irq_priority_regs_next    = IRQ_PRIORITY_REGS_MASK;
      ipr2_next    = IPR2_MASK;
      pir1_next    = ZERO8;
      pir2_next    = ZERO8;
      pie1_next    = ZERO8;
      pie2_next    = ZERO8;
      osctune_next = ZERO8;
      port_a_direction_next   = TRIS_RST;
      intcon_next  = ZERO8;
      ancfg_next   = analog_default_cfg_bit ? ANCFG_ANALOG : ANCFG_DIGITAL;
      pc_next      = PC_RESET;
      sp_next      = SP_RESET;
    end
    // latch is unknown after power-on; cleared here, kept by warm resets
    if (por_cls) begin
      port_a_latch_next = ZERO8;
      tos_next  = PC_RESET;
    end
  end

  // =====================================================================
  // data read path, independent of the program fetch address
  always_comb begin
    rdata_next = ZERO8;
    if (data_addr == ADDR_IRQ_PRIORITY_REGS) begin
      rdata_next = irq_priority_regs_reg;
    end else if (data_addr == ADDR_IPR2) begin
      rdata_next = ipr2_reg;
    end else if (data_addr == ADDR_PIR1) begin
      rdata_next = pir1_reg;
    end else if (data_addr == ADDR_PIR2) begin
      rdata_next = pir2_reg;
    end else if (data_addr == ADDR_PIE1) begin
      rdata_next = pie1_reg;
    end else if (data_addr == ADDR_PIE2) begin
      rdata_next = pie2_reg;
    end else if (data_addr == ADDR_OSCTUNE) begin
      rdata_next = osctune_reg;
    end else if (data_addr == ADDR_PORT_A_DIRECTION) begin
      rdata_next = port_a_direction_reg & pa_mask;
    end else if (data_addr == ADDR_PORT_A_LATCH) begin
      rdata_next = port_a_latch_reg & pa_mask;
    end else if (data_addr == ADDR_PORT_A_PINS) begin
      rdata_next = pa_s2_reg & pa_mask;
    end else if (data_addr == ADDR_INTCON) begin
      rdata_next = intcon_reg;
    end else if (data_addr == ADDR_ANCFG) begin
      rdata_next = {5'h00, ancfg_reg};
    end else if (data_addr == ADDR_RETURN_STACK_POINTER) begin
      rdata_next = {3'h0, sp_reg};
    end
  end

  always_ff @(posedge mclk) begin
    irq_priority_regs_reg    <= irq_priority_regs_next;
    ipr2_reg    <= ipr2_next;
    pir1_reg    <= pir1_next;
    pir2_reg    <= pir2_next;
    pie1_reg    <= pie1_next;
    pie2_reg    <= pie2_next;
    osctune_reg <= osctune_next;
    port_a_direction_reg   <= port_a_direction_next;
    port_a_latch_reg    <= port_a_latch_next;
    intcon_reg  <= intcon_next;
    ancfg_reg   <= ancfg_next;
    pc_reg      <= pc_next;
    tos_reg     <= tos_next;
    sp_reg      <= sp_next;
    rdata_reg   <= reset ? ZERO8 : rdata_next;
  end

  // =====================================================================
  // outputs
  assign data_rdata           = rdata_reg;
  assign prog_addr            = pc_reg;
  assign port_a_latch_out     = port_a_latch_reg & pa_mask;
  assign port_a_direction_out = port_a_direction_reg & pa_mask;
  assign top_of_stack         = tos_reg;
  assign return_stack_pointer = sp_reg;

  // =====================================================================
  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  ipr_warm_ones_a: assert property (warm_cls |=> irq_priority_regs_reg == IRQ_PRIORITY_REGS_MASK && ipr2_reg == IPR2_MASK)
    else $error("priority not all ones after warm reset");
  wake_flag_set_a: assert property (wake.valid && !por_cls && !warm_cls && wake.pir1_set != ZERO8
      |=> (pir1_reg & $past(wake.pir1_set)) == $past(wake.pir1_set))
    else $error("wake cause flag not set");
  wake_vector_a: assert property (wake_vec && !por_cls && !warm_cls
      |=> pc_reg == ($past(wake.high_prio) ? VEC_HIGH : VEC_LOW))
    else $error("wake did not load vector");
  wake_tos_a: assert property (wake_vec && !por_cls && !warm_cls |=> tos_reg == $past(pc_reg))
    else $error("top of stack not loaded with pc");
  wake_sp_inc_a: assert property (wake_vec && !por_cls && !warm_cls
      |=> sp_reg == $past(sp_reg) + SP_ONE)
    else $error("stack pointer not advanced");
  port_a_pins_hide_a: assert property (!osc_frees_ra67 |-> (port_a_latch_out & PORT_A_PINS_HI) == ZERO8
      && (port_a_direction_out & PORT_A_PINS_HI) == ZERO8)
    else $error("port a high bits visible");
  port_a_pins_read_hide_a: assert property (!osc_frees_ra67 && (data_addr == ADDR_PORT_A_LATCH
      || data_addr == ADDR_PORT_A_DIRECTION || data_addr == ADDR_PORT_A_PINS)
      |=> (data_rdata & PORT_A_PINS_HI) == ZERO8)
    else $error("port a high bits read back");
  ancfg_reset_a: assert property ((por_cls || warm_cls)
      |=> ancfg_reg == ($past(analog_default_cfg_bit) ? ANCFG_ANALOG : ANCFG_DIGITAL))
    else $error("analog config reset value wrong");
  prog_bus_a: assert property (data_wr && !por_cls && !warm_cls && !wake_vec
      |=> prog_addr == $past(prog_addr) + PC_STEP)
    else $error("data write disturbed program fetch");
  wake_keep_a: assert property (wake.valid && !data_wr && !por_cls && !warm_cls
      |=> $stable(irq_priority_regs_reg) && $stable(pie1_reg) && $stable(port_a_direction_reg) && $stable(port_a_latch_reg))
    else $error("wake changed kept register");
  sp_clear_a: assert property (warm_cls
      |=> sp_reg == SP_RESET ##1 ($past(data_wr) || sp_reg <= SP_ONE))
    else $error("stack pointer not cleared");

  wake_irq_c: cover property (wake_vec ##1 sp_reg == SP_ONE);
  warm_rst_c: cover property (warm_cls ##1 !warm_cls);
  ra67_free_c: cover property (osc_frees_ra67 && port_a_latch_reg[7]);
  wake_plain_c: cover property (wake.valid && !wake.is_irq);

endmodule

// ---- rwi_tb.sv ----
// self-checking testbench for the reset and wake-up register bank
`timescale 1ns/1ps
module tb
  import rwi_pkg::*;
;
  // ===================================================================
  // design connections
  logic            mclk;
  logic            reset;
  logic            external_reset_pin_n;
  rwi_reset_evt_t  rst_evt;
  rwi_wake_t       wake;
  logic            analog_default_cfg_bit;
  logic            osc_frees_ra67;
  logic [7:0]      port_a_pins_in;
  logic            data_wr;
  logic [3:0]      data_addr;
  logic [7:0]      data_wdata;
  logic [7:0]      data_rdata;
  logic [PC_W-1:0] prog_addr;
  logic [7:0]      port_a_latch_out;
  logic [7:0]      port_a_direction_out;
  logic [PC_W-1:0] top_of_stack;
  logic [SP_W-1:0] return_stack_pointer;
  int              n_errors;
  int              compares;
  int              cycles;

  rwi_reg_bank dut (
    .mclk(mclk), .reset(reset), .external_reset_pin_n(external_reset_pin_n),
    .rst_evt(rst_evt), .wake(wake), .analog_default_cfg_bit(analog_default_cfg_bit),
    .osc_frees_ra67(osc_frees_ra67), .port_a_pins_in(port_a_pins_in),
    .data_wr(data_wr), .data_addr(data_addr), .data_wdata(data_wdata),
    .data_rdata(data_rdata), .prog_addr(prog_addr), .port_a_latch_out(port_a_latch_out),
    .port_a_direction_out(port_a_direction_out), .top_of_stack(top_of_stack),
    .return_stack_pointer(return_stack_pointer));

  // ===================================================================
  // clock and hang guard
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // the whole run needs about 140 cycles; the ceiling leaves ample margin
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 3000) begin
      n_errors++;
      $display("MISMATCH timeout expected finish seen hang");
      end_of_test;
    end
  end

  // ===================================================================
  // shared tasks
  task automatic tick;
    @(posedge mclk);
    #1;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    data_wr = 1'b1;
    data_addr = a;
    data_wdata = d;
    tick;
    data_wr = 1'b0;
    // one idle edge so a following write never re-raises the strobe at once
    tick;
  endtask

  // read data is registered: the address is sampled at one edge, shown after it
  task automatic rd(input logic [3:0] a, input logic [7:0] e, input string nm);
    data_addr = a;
    tick;
    chk(nm, 32'(e), 32'(data_rdata));
  endtask

  task automatic wk(input logic irq, input logic hp, input logic [7:0] ic,
                    input logic [7:0] p1, input logic [7:0] p2);
    wake = '{valid: 1'b1, is_irq: irq, high_prio: hp, intcon_set: ic,
             pir1_set: p1, pir2_set: p2};
    tick;
    wake = '0;
  endtask

  task automatic end_of_test;
    $display("compares %0d n_errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // ===================================================================
  // scenarios
  task automatic t_por;
    logic [7:0] v [0:13];
    v = '{8'hFF, 8'hDF, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hFF, 8'h00, 8'h00,
          8'h00, 8'h00, 8'h00, 8'h00};
    for (int a = 0; a < 14; a++) begin
      rd(4'(a), v[a], "por_value");
    end
    rd(4'hF, 8'h00, "unmapped");
    chk("por_sp", 32'(SP_RESET), 32'(return_stack_pointer));
    $display("test por done");
  endtask

  task automatic t_wake;
    logic [PC_W-1:0] p;
    logic [SP_W-1:0] s;
    wr(ADDR_IRQ_PRIORITY_REGS, 8'h00);
    wr(ADDR_PORT_A_DIRECTION, 8'h3C);
    wr(ADDR_INTCON, 8'h80);
    p = prog_addr;
    s = return_stack_pointer;
    wk(1'b1, 1'b1, 8'h01, 8'h01, 8'hFF);
    chk("pc_high", 32'(VEC_HIGH), 32'(prog_addr));
    chk("tos_high", 32'(p), 32'(top_of_stack));
    chk("sp_high", 32'(s + SP_ONE), 32'(return_stack_pointer));
    rd(ADDR_INTCON, 8'h81, "intcon_flag");
    rd(ADDR_PIR1, 8'h01, "pir1_flag");
    rd(ADDR_PIR2, 8'hDF, "pir2_flag");
    rd(ADDR_IRQ_PRIORITY_REGS, 8'h00, "irq_priority_regs_kept");
    rd(ADDR_PORT_A_DIRECTION, 8'h3C, "port_a_direction_kept");
    wr(ADDR_INTCON, 8'h40);
    p = prog_addr;
    s = return_stack_pointer;
    wk(1'b1, 1'b0, 8'h00, 8'h00, 8'h00);
    chk("pc_low", 32'(VEC_LOW), 32'(prog_addr));
    chk("tos_low", 32'(p), 32'(top_of_stack));
    chk("sp_low", 32'(s + SP_ONE), 32'(return_stack_pointer));
    // with both global enables clear the wake must not divert the fetch
    wr(ADDR_INTCON, 8'h00);
    p = prog_addr;
    s = return_stack_pointer;
    wk(1'b1, 1'b1, 8'h00, 8'h00, 8'h00);
    chk("pc_noirq", 32'(p + PC_STEP), 32'(prog_addr));
    chk("sp_noirq", 32'(s), 32'(return_stack_pointer));
    // a wake with no interrupt behind it only records its cause
    wr(ADDR_INTCON, 8'h80);
    p = prog_addr;
    s = return_stack_pointer;
    wk(1'b0, 1'b1, 8'h00, 8'h02, 8'h00);
    chk("pc_plain", 32'(p + PC_STEP), 32'(prog_addr));
    chk("sp_plain", 32'(s), 32'(return_stack_pointer));
    rd(ADDR_PIR1, 8'h03, "pir1_plain");
    $display("test wake done");
  endtask

  task automatic t_port_a_pins;
    logic [PC_W-1:0] p;
    osc_frees_ra67 = 1'b0;
    port_a_pins_in = 8'hFF;
    p = prog_addr;
    wr(ADDR_PORT_A_DIRECTION, 8'hFF);
    chk("pc_during_write", 32'(p + PC_STEP + PC_STEP), 32'(prog_addr));
    wr(ADDR_PORT_A_LATCH, 8'hFF);
    rd(ADDR_PORT_A_DIRECTION, 8'h3F, "port_a_direction_masked");
    rd(ADDR_PORT_A_LATCH, 8'h3F, "port_a_latch_masked");
    rd(ADDR_PORT_A_PINS, 8'h3F, "port_a_pins_masked");
    chk("dir_out_masked", 32'h3F, 32'(port_a_direction_out));
    chk("lat_out_masked", 32'h3F, 32'(port_a_latch_out));
    osc_frees_ra67 = 1'b1;
    rd(ADDR_PORT_A_PINS, 8'hFF, "port_a_pins_freed");
    chk("dir_out_freed", 32'hFF, 32'(port_a_direction_out));
    $display("test port_a_pins done");
  endtask

  // kinds 0..4 follow the event struct from its top bit, kind 5 is the pin
  task automatic t_resets;
    for (int i = 0; i < 6; i++) begin
      analog_default_cfg_bit = i[0];
      wr(ADDR_IRQ_PRIORITY_REGS, 8'h00);
      wr(ADDR_PORT_A_LATCH, 8'h5A);
      wr(ADDR_INTCON, 8'h80);
      wk(1'b1, 1'b1, 8'h00, 8'h00, 8'h00);
      if (i < 5) begin
        rst_evt = rwi_reset_evt_t'(5'h10 >> i);
        tick;
        rst_evt = '0;
      end else begin
        external_reset_pin_n = 1'b0;
        repeat (4) tick;
        external_reset_pin_n = 1'b1;
        repeat (4) tick;
      end
      chk("sp_after_reset", 32'(SP_RESET), 32'(return_stack_pointer));
      rd(ADDR_IRQ_PRIORITY_REGS, 8'hFF, "irq_priority_regs_after_reset");
      rd(ADDR_ANCFG, i[0] ? 8'h00 : 8'h07, "ancfg_after_reset");
      rd(ADDR_PORT_A_LATCH, (i < 2) ? 8'h00 : 8'h5A, "port_a_latch_after_reset");
      rd(ADDR_INTCON, 8'h00, "intcon_after_reset");
    end
    $display("test resets done");
  endtask

  // ===================================================================
  // main sequence
  initial begin
    n_errors = 0;
    compares = 0;
    cycles = 0;
    reset = 1'b1;
    external_reset_pin_n = 1'b1;
    rst_evt = '0;
    wake = '0;
    analog_default_cfg_bit = 1'b1;
    osc_frees_ra67 = 1'b1;
    port_a_pins_in = 8'h00;
    data_wr = 1'b0;
    data_addr = 4'h0;
    data_wdata = 8'h00;
    repeat (16) tick;
    reset = 1'b0;
    t_por;
    t_wake;
    t_port_a_pins;
    t_resets;
    end_of_test;
  end
endmodule
